// [bbx_core.sv]
// Byte and bit instruction execution core with file space, port bank and tick counter
`timescale 1ns/10ps
`default_nettype none
`include "bbx_map.svh"
// Behaviour
// - Any program counter write except the absolute jump clears counter bit 8.
// - Read-modify-write of the I/O bank uses pin levels, not the latch.
// - Direction load with operand 6 copies accumulator into direction latches.
// - Writing the tick counter clears the prescaler when assigned; add and AND need dest one, bit set/clear always write.
// - Add sums accumulator and file register, updating carry, half carry, zero.
// - Destination bit zero targets accumulator; one targets the file register.
// - AND with file ANDs accumulator and register, routes by dest, sets zero only.
// - AND literal ANDs accumulator with 8-bit immediate into accumulator, sets zero.
// - Bit clear zeroes the chosen bit of the register; flags untouched.
// - Bit set ones the chosen bit of the register; flags untouched.
// - Skip-if-low discards the prefetched instruction when the bit is zero.
// - Skip-if-high discards the prefetched instruction when the bit is one.
// - An instruction cycle is four clocks; taken skips and jumps cost two cycles.
module bbx_core (
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_arst_n,
  // Program memory
  output logic [8:0] o_pc,
  input wire logic [11:0] i_instr,
  // Second I/O bank pins
  input wire logic [7:0] i_io_pin,
  output logic [7:0] o_io_out,
  output logic [7:0] o_io_oe,
  // Timer configuration and state
  input wire logic i_ps_to_tick,
  output logic [7:0] o_tick_count,
  output logic [7:0] o_prescale,
  // Core state
  output logic [7:0] o_acc,
  output logic [2:0] o_flags,
  output logic o_cyc_end
);
  function automatic bbx_pkg::bbx_instr_s bbx_decode(input logic [11:0] w);
    bbx_pkg::bbx_instr_s r;
    r.op = bbx_pkg::OP_IDLE;
    r.dest = w[5];
    r.faddr = w[4:0];
    r.bsel = w[7:5];
    r.lit = w[8:0];
    if (w[11:6] == `BBX_OP_ADD_HI) r.op = bbx_pkg::OP_ADD;
    else if (w[11:6] == `BBX_OP_AND_HI) r.op = bbx_pkg::OP_AND;
    else if (w[11:8] == `BBX_OP_BCLR_HI) r.op = bbx_pkg::OP_BCLR;
    else if (w[11:8] == `BBX_OP_BSET_HI) r.op = bbx_pkg::OP_BSET;
    else if (w[11:8] == `BBX_OP_SKL_HI) r.op = bbx_pkg::OP_SKL;
    else if (w[11:8] == `BBX_OP_SKH_HI) r.op = bbx_pkg::OP_SKH;
    else if (w[11:8] == `BBX_OP_ANDL_HI) r.op = bbx_pkg::OP_ANDL;
    else if (w[11:9] == `BBX_OP_JUMP_HI) r.op = bbx_pkg::OP_JUMP;
    // The all-zero word must stay idle, since flushed slots are refilled with it
    else if (w[11:3] == `BBX_OP_LOAD_DIRECTION_LATCHES_HI && w != `BBX_OP_IDLE) r.op = bbx_pkg::OP_LOAD_DIRECTION_LATCHES;
    return r;
  endfunction : bbx_decode

  logic [1:0] phase_q;
  logic cyc_en;
  logic [8:0] pc_q;
  logic [8:0] pc_d;
  bbx_pkg::bbx_instr_s ir_q;
  logic [7:0] acc_q;
  logic [2:0] flags_q;
  logic [2:0] flags_d;
  logic [7:0] dir_q;
  logic [7:0] latch_q;
  logic [7:0] tick_q;
  logic [7:0] ps_q;
  logic [7:0] pin_m;
  logic [7:0] pin_s;
  logic [7:0] ram_rd;
  logic [7:0] fval;
  logic [7:0] res;
  logic [8:0] sum;
  logic [4:0] hsum;
  logic wr_file;
  logic wr_acc;
  logic bit_val;
  logic skip;
  logic flush;
  logic tick_wr;

  // The four-phase divider gives the instruction cycle; data settles in the middle phases
  always_ff @(posedge i_mclk or negedge i_arst_n)
  begin
    if (!i_arst_n) phase_q <= 2'h0;
    else phase_q <= phase_q + 2'h1;
  end
  assign cyc_en = (phase_q == `BBX_PHASE_LAST);

  // Pins come from outside the clock domain
  always_ff @(posedge i_mclk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      pin_m <= 8'h00;
      pin_s <= 8'h00;
    end
    else
    begin
      pin_m <= i_io_pin;
      pin_s <= pin_m;
    end
  end

  bbx_file_ram u_ram (
    .i_mclk(i_mclk),
    .i_we(cyc_en && wr_file && (ir_q.faddr > `BBX_ADDR_IO)),
    .i_waddr(ir_q.faddr),
    .i_wdata(res),
    .i_raddr(ir_q.faddr),
    .o_rdata_q(ram_rd)
  );

  // Operand fetch from the file space
  always_comb
  begin
    unique case (ir_q.faddr)
      `BBX_ADDR_TICK: fval = tick_q;
      `BBX_ADDR_PCL: fval = pc_q[7:0];
      `BBX_ADDR_STATUS: fval = {5'h00, flags_q};
      `BBX_ADDR_IO: fval = pin_s;
      default: fval = ram_rd;
    endcase
  end

  // Execute
  always_comb
  begin
    sum = {1'b0, acc_q} + {1'b0, fval};
    hsum = {1'b0, acc_q[3:0]} + {1'b0, fval[3:0]};
    res = fval;
    wr_file = 1'b0;
    wr_acc = 1'b0;
    flags_d = flags_q;
    bit_val = fval[ir_q.bsel];
    skip = 1'b0;
    unique case (ir_q.op)
      bbx_pkg::OP_ADD:
      begin
        res = sum[7:0];
        flags_d[`BBX_FLAG_C] = sum[8];
        flags_d[`BBX_FLAG_HB] = hsum[4];
        flags_d[`BBX_FLAG_Z] = (sum[7:0] == 8'h00);
        wr_file = ir_q.dest;
        wr_acc = !ir_q.dest;
      end
      bbx_pkg::OP_AND:
      begin
        res = acc_q & fval;
        flags_d[`BBX_FLAG_Z] = ((acc_q & fval) == 8'h00);
        wr_file = ir_q.dest;
        wr_acc = !ir_q.dest;
      end
      bbx_pkg::OP_ANDL:
      begin
        res = acc_q & ir_q.lit[7:0];
        flags_d[`BBX_FLAG_Z] = ((acc_q & ir_q.lit[7:0]) == 8'h00);
        wr_acc = 1'b1;
      end
      bbx_pkg::OP_BCLR:
      begin
        res[ir_q.bsel] = 1'b0;
        wr_file = 1'b1;
      end
      bbx_pkg::OP_BSET:
      begin
        res[ir_q.bsel] = 1'b1;
        wr_file = 1'b1;
      end
      bbx_pkg::OP_SKL: skip = !bit_val;
      bbx_pkg::OP_SKH: skip = bit_val;
      default: res = fval;
    endcase
    // A write to the status register loses to the flag update of the same op
    if (wr_file && ir_q.faddr == `BBX_ADDR_STATUS && ir_q.op != bbx_pkg::OP_ADD
        && ir_q.op != bbx_pkg::OP_AND)
    begin
      flags_d = res[2:0];
    end
    if (wr_file && ir_q.faddr == `BBX_ADDR_STATUS && ir_q.op == bbx_pkg::OP_AND)
    begin
      flags_d = {flags_d[`BBX_FLAG_Z], res[1:0]};
    end
  end

  assign tick_wr = wr_file && (ir_q.faddr == `BBX_ADDR_TICK);

  // Program counter; a taken skip, jump or counter write refetches, costing a cycle
  always_comb
  begin
    pc_d = pc_q + 9'h001;
    flush = skip;
    if (ir_q.op == bbx_pkg::OP_JUMP)
    begin
      pc_d = ir_q.lit;
      flush = 1'b1;
    end
    else if (wr_file && ir_q.faddr == `BBX_ADDR_PCL)
    begin
      pc_d = {1'b0, res};
      flush = 1'b1;
    end
  end

  always_ff @(posedge i_mclk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      pc_q <= `BBX_RST_PC;
      ir_q <= '{op: bbx_pkg::OP_IDLE, default: '0};
    end
    else if (cyc_en)
    begin
      pc_q <= pc_d;
      ir_q <= flush ? bbx_decode(`BBX_OP_IDLE) : bbx_decode(i_instr);
    end
  end

  always_ff @(posedge i_mclk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      acc_q <= `BBX_RST_ACC;
      flags_q <= `BBX_RST_FLAGS;
    end
    else if (cyc_en)
    begin
      if (wr_acc) acc_q <= res;
      flags_q <= flags_d;
    end
  end

  // Port bank latches; the written value started from the pin levels
  always_ff @(posedge i_mclk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      latch_q <= `BBX_RST_LATCH;
      dir_q <= `BBX_RST_DIR;
    end
    else if (cyc_en)
    begin
      if (wr_file && ir_q.faddr == `BBX_ADDR_IO) latch_q <= res;
      if (ir_q.op == bbx_pkg::OP_LOAD_DIRECTION_LATCHES && ir_q.lit[2:0] == `BBX_LOAD_DIRECTION_LATCHES_IO)
      begin
        dir_q <= acc_q;
      end
    end
  end

  // Tick counter with optional prescaler
  always_ff @(posedge i_mclk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      tick_q <= 8'h00;
      ps_q <= 8'h00;
    end
    else if (cyc_en)
    begin
      if (tick_wr)
      begin
        tick_q <= res;
        if (i_ps_to_tick) ps_q <= 8'h00;
      end
      else if (i_ps_to_tick)
      begin
        ps_q <= ps_q + 8'h01;
        if (ps_q == `BBX_PS_MAX) tick_q <= tick_q + 8'h01;
      end
      else
      begin
        tick_q <= tick_q + 8'h01;
      end
    end
  end

  assign o_pc = pc_q;
  assign o_io_out = latch_q;
  assign o_io_oe = ~dir_q;
  assign o_tick_count = tick_q;
  assign o_prescale = ps_q;
  assign o_acc = acc_q;
  assign o_flags = flags_q;
  assign o_cyc_end = cyc_en;

  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_arst_n);

  a_pc_bit8_clear: assert property (cyc_en && wr_file && ir_q.faddr == `BBX_ADDR_PCL
    |=> pc_q[8] == 1'b0 && ir_q.op == bbx_pkg::OP_IDLE) else $error("pc bit 8 not cleared");
  a_io_pin_rmw: assert property (cyc_en && ir_q.op == bbx_pkg::OP_BCLR
    && ir_q.faddr == `BBX_ADDR_IO |=> latch_q == ($past(pin_s) & ~(8'h01 << $past(ir_q.bsel))))
    else $error("port write did not start from pins");
  a_dir_load: assert property (cyc_en && ir_q.op == bbx_pkg::OP_LOAD_DIRECTION_LATCHES
    && ir_q.lit[2:0] == `BBX_LOAD_DIRECTION_LATCHES_IO |=> o_io_oe == ~$past(acc_q))
    else $error("direction latches not loaded");
  a_ps_clear: assert property (cyc_en && tick_wr && i_ps_to_tick |=> ps_q == 8'h00)
    else $error("prescaler not cleared");
  a_add_result: assert property (cyc_en && ir_q.op == bbx_pkg::OP_ADD && !ir_q.dest
    |=> acc_q == $past(sum[7:0]) && flags_q[`BBX_FLAG_C] == $past(sum[8]))
    else $error("add result or carry wrong");
  a_dest_file: assert property (cyc_en && (ir_q.op == bbx_pkg::OP_AND
    || ir_q.op == bbx_pkg::OP_ADD) && ir_q.dest |=> $stable(acc_q))
    else $error("accumulator changed on file destination");
  a_and_zero: assert property (cyc_en && ir_q.op == bbx_pkg::OP_ANDL
    |=> flags_q[`BBX_FLAG_Z] == (acc_q == 8'h00) && $stable(flags_q[1:0]))
    else $error("zero flag wrong after AND");
  a_bit_flags: assert property (cyc_en && (ir_q.op == bbx_pkg::OP_BSET
    || ir_q.op == bbx_pkg::OP_BCLR) && ir_q.faddr != `BBX_ADDR_STATUS |=> $stable(flags_q))
    else $error("bit op changed flags");
  a_skip_low: assert property (cyc_en && ir_q.op == bbx_pkg::OP_SKL && !bit_val
    |=> ir_q.op == bbx_pkg::OP_IDLE) else $error("skip on low not taken");
  a_skip_high: assert property (cyc_en && ir_q.op == bbx_pkg::OP_SKH && !bit_val
    |=> ir_q == $past(bbx_decode(i_instr))) else $error("skip on high taken wrongly");
  a_cycle_len: assert property (cyc_en |=> !cyc_en [*3] ##1 cyc_en)
    else $error("instruction cycle not four clocks");

  c_skip_taken: cover property (cyc_en && skip);
  c_jump: cover property (cyc_en && ir_q.op == bbx_pkg::OP_JUMP);
  c_add_carry: cover property (cyc_en && ir_q.op == bbx_pkg::OP_ADD && sum[8]);
  c_tick_write: cover property (cyc_en && tick_wr && i_ps_to_tick);
endmodule : bbx_core
`default_nettype wire

// [bbx_map.svh]
// Encodings, file addresses, flag positions, reset values and timing counts for the core
`ifndef BBX_MAP_SVH
`define BBX_MAP_SVH
`define BBX_OSC_PER_CYC 4
`define BBX_PHASE_LAST 2'h3
`define BBX_OP_IDLE 12'h000
`define BBX_OP_LOAD_DIRECTION_LATCHES_HI 9'h000
`define BBX_OP_ADD_HI 6'h07
`define BBX_OP_AND_HI 6'h05
`define BBX_OP_BCLR_HI 4'h4
`define BBX_OP_BSET_HI 4'h5
`define BBX_OP_SKL_HI 4'h6
`define BBX_OP_SKH_HI 4'h7
`define BBX_OP_JUMP_HI 3'h5
`define BBX_OP_ANDL_HI 4'hE
`define BBX_ADDR_TICK 5'h01
`define BBX_ADDR_PCL 5'h02
`define BBX_ADDR_STATUS 5'h03
`define BBX_ADDR_IO 5'h06
`define BBX_LOAD_DIRECTION_LATCHES_IO 3'h6
`define BBX_FLAG_C 0
`define BBX_FLAG_HB 1
`define BBX_FLAG_Z 2
`define BBX_RST_PC 9'h000
`define BBX_RST_ACC 8'h00
`define BBX_RST_FLAGS 3'h0
`define BBX_RST_DIR 8'hFF
`define BBX_RST_LATCH 8'h00
`define BBX_PS_MAX 8'hFF
`endif

// [bbx_pkg.sv]
// Types shared by the byte and bit instruction core
package bbx_pkg;
  typedef enum logic [3:0] {
    OP_IDLE, OP_ADD, OP_AND, OP_ANDL, OP_BCLR, OP_BSET, OP_SKL, OP_SKH, OP_JUMP, OP_LOAD_DIRECTION_LATCHES
  } bbx_op_e;
  typedef struct packed {
    bbx_op_e op;
    logic dest;
    logic [4:0] faddr;
    logic [2:0] bsel;
    logic [8:0] lit;
  } bbx_instr_s;
endpackage : bbx_pkg

// [bbx_file_ram.sv]
// 32 x 8 general file register store with registered read data
`timescale 1ns/10ps
`default_nettype none
module bbx_file_ram (
  // Clock
  input wire logic i_mclk,
  // Write port
  input wire logic i_we,
  input wire logic [4:0] i_waddr,
  input wire logic [7:0] i_wdata,
  // Read port
  input wire logic [4:0] i_raddr,
  output logic [7:0] o_rdata_q
);
  logic [7:0] mem [0:31];

  always_ff @(posedge i_mclk)
  begin
    if (i_we)
    begin
      mem[i_waddr] <= i_wdata;
    end
  end

  always_ff @(posedge i_mclk)
  begin
    o_rdata_q <= mem[i_raddr];
  end
endmodule : bbx_file_ram
`default_nettype wire

// [bbx_pmem_model.sv]
// Program memory model answering the core's fetch address
`timescale 1ns/10ps
`default_nettype none
module bbx_pmem_model (
  // Fetch side
  input wire logic i_mclk,
  input wire logic i_cyc_end,
  input wire logic [8:0] i_pc,
  // Instruction word
  output logic [11:0] o_instr
);
  logic [11:0] mem [512];
  logic [11:0] junk_q = 12'hA5C;
  initial
  begin
    for (int i = 0; i < 512; i++)
      mem[i] = 12'h000;
  end
  // Word is owed only in the cycle-end clock; a moving pattern elsewhere exposes early sampling
  always @(posedge i_mclk)
    junk_q <= ~junk_q ^ {3'h0, i_pc};
  assign o_instr = i_cyc_end ? mem[i_pc] : junk_q;
endmodule : bbx_pmem_model
`default_nettype wire

// [testbench.sv]
// Bench running a random program against an instruction-level model
`timescale 1ns/10ps
`default_nettype none
module testbench;
  typedef struct packed {
    logic [8:0] pc;
    logic [7:0] acc;
    logic [2:0] fl;
    logic [7:0] oe;
    logic [7:0] lat;
    logic [7:0] ps;
    logic [7:0] tk;
  } bbx_exp_s;
  localparam int NB = 45;
  localparam int NC = 170;
  logic i_mclk;
  logic i_arst_n = 1'h0;
  logic i_ps_to_tick = 1'h1;
  logic [7:0] i_io_pin = 8'h00;
  logic [11:0] instr, ir, w;
  logic [8:0] o_pc, fpc, nfpc, sum;
  logic [7:0] o_io_out, o_io_oe, o_prescale, o_acc, acc, dir, lat, pins, fv, res, bm;
  logic [7:0] o_tick_count, tk, ps;
  logic [7:0] ram [32];
  logic [2:0] o_flags, fl;
  logic [4:0] f;
  logic [31:0] r;
  logic [31:0] seed = 32'h00000059;
  logic o_cyc_end, kill, wr, psz, asg;
  int num_errors = 0;
  int checks = 0;
  int ncl = 0;
  int lst = -1;
  bbx_exp_s exp_q [$];
  bbx_exp_s e;
  bbx_core dut (
    .i_mclk(i_mclk),
    .i_arst_n(i_arst_n),
    .o_pc(o_pc),
    .i_instr(instr),
    .i_io_pin(i_io_pin),
    .o_io_out(o_io_out),
    .o_io_oe(o_io_oe),
    .i_ps_to_tick(i_ps_to_tick),
    .o_tick_count(o_tick_count),
    .o_prescale(o_prescale),
    .o_acc(o_acc),
    .o_flags(o_flags),
    .o_cyc_end(o_cyc_end)
  );
  bbx_pmem_model u_pmem (
    .i_mclk(i_mclk),
    .i_cyc_end(o_cyc_end),
    .i_pc(o_pc),
    .o_instr(instr)
  );
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : xs
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("MISMATCH t=%0t seen=%0h exp=%0h", $time, seen, exp);
    end
  endtask : check
  task automatic complete_run();
    if (num_errors == 0 && checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : complete_run
  initial
  begin
    i_mclk = 1'h0;
    forever #50 i_mclk = ~i_mclk;
  end
  initial
  begin
    @(posedge i_mclk);
    r = xs();
    pins = r[7:0];
    i_io_pin <= pins;
    // Prologue clears the accumulator, writes the tick counter, then clears RAM files 7 to 31
    u_pmem.mem[0] = 12'hE00;
    u_pmem.mem[1] = 12'h501;
    for (int i = 7; i < 32; i++)
      u_pmem.mem[i - 5] = {7'h0B, 5'(i)};
    for (int i = 0; i < NB; i++)
    begin
      r = xs();
      f = 5'h06 + 5'(r[7:0] % 26);
      case (i % 9)
        0: w = {6'h07, r[8], f};
        1: w = {6'h05, r[8], f};
        2: w = {4'hE, r[15:8]};
        3: w = {4'h4, r[10:8], f};
        4: w = {4'h5, r[10:8], f};
        5: w = {4'h6, r[10:8], f};
        6: w = {4'h7, r[10:8], f};
        7: w = {9'h000, r[8] ? 3'h6 : 3'h5};
        default: w = {3'h5, 9'(i + 29)};
      endcase
      u_pmem.mem[27 + i] = w;
    end
    // Jump high sets bit 8; the pc write through file 02 must clear it
    u_pmem.mem[72] = 12'hB00;
    u_pmem.mem[73] = 12'hB00;
    u_pmem.mem[256] = 12'hE00;
    u_pmem.mem[257] = 12'h162;
    acc = 8'h00;
    dir = 8'hFF;
    lat = 8'h00;
    fl = 3'h0;
    fpc = 9'h000;
    ir = 12'h000;
    kill = 1'h0;
    tk = 8'h00;
    ps = 8'h00;
    for (int c = 0; c < NC; c++)
    begin
      w = kill ? 12'h000 : ir;
      {kill, wr, psz} = 3'h0;
      nfpc = fpc + 9'h001;
      f = w[4:0];
      fv = (f == 5'h06) ? pins : ((f == 5'h01) ? tk : ram[f]);
      bm = 8'h01 << w[7:5];
      res = acc;
      casez (w)
        12'b0001_11??_????:
        begin
          sum = 9'(acc) + 9'(fv);
          res = sum[7:0];
          fl = {res == 8'h00, 5'(acc[3:0]) + 5'(fv[3:0]) > 5'h0F, sum[8]};
          wr = w[5];
        end
        12'b0001_01??_????:
        begin
          res = acc & fv;
          fl[2] = res == 8'h00;
          wr = w[5];
        end
        12'b1110_????_????:
        begin
          res = acc & w[7:0];
          fl[2] = res == 8'h00;
        end
        12'b0100_????_????: {wr, res} = {1'h1, fv & ~bm};
        12'b0101_????_????: {wr, res} = {1'h1, fv | bm};
        12'b0110_????_????: kill = (fv & bm) == 8'h00;
        12'b0111_????_????: kill = (fv & bm) != 8'h00;
        12'b101?_????_????: {kill, nfpc} = {1'h1, w[8:0]};
        12'h006: dir = acc;
        default: ;
      endcase
      if (!wr)
        acc = res;
      else if (f == 5'h06)
        lat = res;
      else if (f == 5'h02)
        {kill, nfpc} = {2'h2, res};
      else if (f == 5'h01)
        {psz, tk} = {1'h1, res};
      else
        ram[f] = res;
      // Prescaler is assigned to the tick counter for the first half of the run only
      asg = (c < NC / 2);
      if (psz && asg)
        ps = 8'h00;
      else if (!psz && asg)
      begin
        tk = tk + 8'(ps == 8'hFF);
        ps = ps + 8'h01;
      end
      else if (!psz)
        tk = tk + 8'h01;
      ir = u_pmem.mem[fpc];
      fpc = nfpc;
      exp_q.push_back({fpc, acc, fl, ~dir, lat, ps, tk});
    end
    repeat (5) @(posedge i_mclk);
    i_arst_n <= 1'h1;
    for (int k = 0; k < NC * 4 + 40 && exp_q.size() != 0; k++)
    begin
      @(posedge i_mclk);
      // Half the notes taken: unassign the prescaler well clear of the next cycle end
      if (exp_q.size() <= NC - NC / 2)
        i_ps_to_tick <= 1'h0;
    end
    if (exp_q.size() != 0)
      num_errors++;
    complete_run();
  end
  always @(posedge i_mclk)
    ncl <= ncl + 1;
  always @(negedge i_mclk)
    if (o_cyc_end === 1'h1 && exp_q.size() != 0)
    begin
      if (lst >= 0)
        check(32'(ncl - lst), 32'h4);
      lst = ncl;
      @(negedge i_mclk);
      e = exp_q.pop_front();
      check(32'(o_pc), 32'(e.pc));
      check(32'(o_acc), 32'(e.acc));
      check(32'(o_flags), 32'(e.fl));
      check(32'(o_io_oe), 32'(e.oe));
      check(32'(o_io_out), 32'(e.lat));
      check(32'(o_prescale), 32'(e.ps));
      check(32'(o_tick_count), 32'(e.tk));
    end
  initial
  begin
    repeat (NC * 4 + 400) @(posedge i_mclk);
    num_errors++;
    complete_run();
  end
endmodule : testbench
`default_nettype wire
